// ==== design/rcm_regs.svh ====
// Timing constants and reset values for the remote carrier mask generator
`ifndef RCM_REGS_SVH
`define RCM_REGS_SVH
`define RCM_SYS_CLK_HZ 200000000
`define RCM_PCLK_HZ 8000000
`define RCM_PCLK_DIV (`RCM_SYS_CLK_HZ / `RCM_PCLK_HZ)
`define RCM_CNT_W 16
`define RCM_COUNT_RESET 16'h0000
`define RCM_CARRIER_HZ 40000
`define RCM_CARRIER_DUTY_PCT 30
`define RCM_CARRIER_PERIOD_COUNT ((`RCM_PCLK_HZ / `RCM_CARRIER_HZ) - 1)
`define RCM_CARRIER_HIGH_COUNT ((((`RCM_PCLK_HZ / `RCM_CARRIER_HZ) * `RCM_CARRIER_DUTY_PCT) / 100) - 1)
`endif

// ==== design/rcm_pkg.sv ====
// Types shared by the remote carrier mask generator
package rcm_pkg;
  // Period counts loaded by software, one per channel
  typedef struct packed {
    logic [15:0] mask_period_count;
    logic [15:0] mask_active_count;
    logic [15:0] carrier_period_count;
    logic [15:0] carrier_high_count;
  } rcm_counts_t;

  // Channel request pulses
  typedef struct packed {
    logic mask_rise_request;
    logic mask_channel_b_request;
    logic carrier_period_request;
    logic carrier_high_request;
  } rcm_requests_t;

  typedef enum logic [1:0] {
    RCM_IDLE = 2'b00,
    RCM_RUN = 2'b01
  } rcm_state_t;
endpackage

// ==== design/rcm_remote_carrier_mask_pwm.sv ====
// Remote-control carrier and mask waveform generator on four timer channels
// Summary of operation
// - Output is carrier combined with mask waveform
// - Channels four and five make the carrier
// - Carrier from loaded counts; 199 and 59 give 40 kHz, 30 percent high
// - Channels two and three make the mask
// - All channels count on 8 MHz clock
// - Channel three underflow ends mask active part
// - Mask rise raises channel two request
// - Zero active count gives no remote output
// - Channel five underflow drives carrier low
// - Channel four underflow starts five, carrier high
// - Result drives dedicated remote output pin
// - Select bit routes result; else timer outputs
// - Enable low stops clock, ignores writes, resets
`include "rcm_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module rcm_remote_carrier_mask_pwm #(
  parameter int unsigned CNT_W = `RCM_CNT_W,
  parameter int unsigned PCLK_DIV = `RCM_PCLK_DIV
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic timer_array_enable,
  input wire logic remote_output_select,
  input wire logic count_write,
  input wire rcm_pkg::rcm_counts_t count_data,
  input wire logic start,
  input wire logic stop,
  input wire logic key_input_port,
  output logic key_pressed,
  output logic remote_output_pin,
  output logic [3:0] timer_output,
  output logic running,
  output rcm_pkg::rcm_requests_t requests
);
  // Default carrier counts, checked against the counter width
  localparam int unsigned CARRIER_PERIOD_DEF = `RCM_CARRIER_PERIOD_COUNT;
  localparam int unsigned CARRIER_HIGH_DEF = `RCM_CARRIER_HIGH_COUNT;

  initial begin
    if (CNT_W < 8) begin
      $error("rcm_remote_carrier_mask_pwm: counter narrower than 8 bits");
    end
    if (CNT_W > 16) begin
      $error("rcm_remote_carrier_mask_pwm: counter wider than its data field");
    end
    if (PCLK_DIV < 1) begin
      $error("rcm_remote_carrier_mask_pwm: divider below one");
    end
    if (PCLK_DIV > 256) begin
      $error("rcm_remote_carrier_mask_pwm: divider beyond its 8-bit counter");
    end
    if (CARRIER_PERIOD_DEF >= (1 << CNT_W) || CARRIER_HIGH_DEF >= (1 << CNT_W)) begin
      $error("rcm_remote_carrier_mask_pwm: carrier counts do not fit counter");
    end
  end

  rcm_pkg::rcm_counts_t data_reg;
  rcm_pkg::rcm_state_t state;
  logic [CNT_W-1:0] cnt2;
  logic [CNT_W-1:0] cnt3;
  logic [CNT_W-1:0] cnt4;
  logic [CNT_W-1:0] cnt5;
  logic [7:0] div_cnt;
  logic pclk_en;
  logic key_meta;
  logic key_sync;
  logic carrier;
  logic mask;
  logic ch5_run;
  logic ch3_run;
  logic uf2;
  logic uf3;
  logic uf4;
  logic uf5;
  logic [CNT_W-1:0] d2;
  logic [CNT_W-1:0] d3;
  logic [CNT_W-1:0] d4;
  logic [CNT_W-1:0] d5;

  assign d2 = data_reg.mask_period_count[CNT_W-1:0];
  assign d3 = data_reg.mask_active_count[CNT_W-1:0];
  assign d4 = data_reg.carrier_period_count[CNT_W-1:0];
  assign d5 = data_reg.carrier_high_count[CNT_W-1:0];

  // Key pin synchroniser, level active low
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      key_meta <= 1'b1;
      key_sync <= 1'b1;
    end else begin
      key_meta <= key_input_port;
      key_sync <= key_meta;
    end
  end

  // Pressed flag read only from the second stage
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      key_pressed <= 1'b0;
    end else begin
      key_pressed <= ~key_sync;
    end
  end

  // 8 MHz count enable from system clock
  always_ff @(posedge sys_clk) begin
    if (srst || !timer_array_enable) begin
      div_cnt <= 8'h00;
    end else if (div_cnt == 8'(PCLK_DIV - 1)) begin
      div_cnt <= 8'h00;
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst || !timer_array_enable) begin
      pclk_en <= 1'b0;
    end else begin
      pclk_en <= (div_cnt == 8'(PCLK_DIV - 1));
    end
  end

  // Count data registers; writes ignored while disabled
  always_ff @(posedge sys_clk) begin
    if (srst || !timer_array_enable) begin
      data_reg <= '0;
    end else if (count_write) begin
      data_reg <= count_data;
    end
  end

  // Run state
  always_ff @(posedge sys_clk) begin
    if (srst || !timer_array_enable) begin
      state <= rcm_pkg::RCM_IDLE;
    end else begin
      case (state)
        rcm_pkg::RCM_IDLE: begin
          if (start) begin
            state <= rcm_pkg::RCM_RUN;
          end
        end
        rcm_pkg::RCM_RUN: begin
          if (stop) begin
            state <= rcm_pkg::RCM_IDLE;
          end
        end
        default: begin
          state <= rcm_pkg::RCM_IDLE;
        end
      endcase
    end
  end

  wire logic run = (state == rcm_pkg::RCM_RUN);
  wire logic tick = run && pclk_en;
  assign uf2 = tick && (cnt2 == '0);
  assign uf3 = tick && ch3_run && (cnt3 == '0);
  assign uf4 = tick && (cnt4 == '0);
  assign uf5 = tick && ch5_run && (cnt5 == '0);

  // Carrier period channel: free-running, reloads at underflow
  always_ff @(posedge sys_clk) begin
    if (srst || !run) begin
      cnt4 <= d4;
    end else if (uf4) begin
      cnt4 <= d4;
    end else if (tick) begin
      cnt4 <= cnt4 - 1'b1;
    end
  end

  // Carrier high channel: one-shot started by period underflow
  always_ff @(posedge sys_clk) begin
    if (srst || !run) begin
      cnt5 <= d5;
    end else if (uf4) begin
      cnt5 <= d5;
    end else if (tick && ch5_run && !uf5) begin
      cnt5 <= cnt5 - 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst || !run) begin
      ch5_run <= 1'b0;
    end else if (uf4) begin
      ch5_run <= 1'b1;
    end else if (uf5) begin
      ch5_run <= 1'b0;
    end
  end

  // Internal carrier level; period restart wins over high-time end
  always_ff @(posedge sys_clk) begin
    if (srst || !run) begin
      carrier <= 1'b0;
    end else if (uf4) begin
      carrier <= 1'b1;
    end else if (uf5) begin
      carrier <= 1'b0;
    end
  end

  // Mask period channel: mask set high at each underflow if active count nonzero
  always_ff @(posedge sys_clk) begin
    if (srst || !run) begin
      cnt2 <= d2;
    end else if (uf2) begin
      cnt2 <= d2;
    end else if (tick) begin
      cnt2 <= cnt2 - 1'b1;
    end
  end

  // Mask active channel: zero count gives no active interval
  always_ff @(posedge sys_clk) begin
    if (srst || !run) begin
      cnt3 <= '0;
    end else if (uf2) begin
      cnt3 <= d3;
    end else if (tick && ch3_run && !uf3) begin
      cnt3 <= cnt3 - 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst || !run) begin
      ch3_run <= 1'b0;
    end else if (uf2) begin
      ch3_run <= (d3 != '0);
    end else if (uf3) begin
      ch3_run <= 1'b0;
    end
  end

  // Mask stays low until the first period underflow
  always_ff @(posedge sys_clk) begin
    if (srst || !run) begin
      mask <= 1'b0;
    end else if (uf2) begin
      mask <= (d3 != '0);
    end else if (uf3) begin
      mask <= 1'b0;
    end
  end

  // Request pulses, one cycle each
  always_ff @(posedge sys_clk) begin
    if (srst || !timer_array_enable) begin
      requests <= '0;
    end else begin
      requests.mask_rise_request <= uf2;
      requests.mask_channel_b_request <= uf3;
      requests.carrier_period_request <= uf4;
      requests.carrier_high_request <= uf5;
    end
  end

  // Run status
  always_ff @(posedge sys_clk) begin
    if (srst || !timer_array_enable) begin
      running <= 1'b0;
    end else begin
      running <= run;
    end
  end

  // Remote pin carries the gated carrier only when selected
  always_ff @(posedge sys_clk) begin
    if (srst || !timer_array_enable) begin
      remote_output_pin <= 1'b0;
    end else if (remote_output_select) begin
      remote_output_pin <= carrier & mask;
    end else begin
      remote_output_pin <= 1'b0;
    end
  end

  // Plain timer outputs only when the remote path is off
  always_ff @(posedge sys_clk) begin
    if (srst || !timer_array_enable) begin
      timer_output <= 4'h0;
    end else if (remote_output_select) begin
      timer_output <= 4'h0;
    end else begin
      timer_output <= {carrier, ch5_run, ch3_run, mask};
    end
  end
endmodule
`default_nettype wire

// ==== verification/rcm_pwm_properties.sv ====
// Port checks for the remote carrier mask generator
`timescale 1ns/1ps
`default_nettype none
module rcm_pwm_chk #(
  parameter int unsigned CNT_W = 16,
  parameter int unsigned PCLK_DIV = 25
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic timer_array_enable,
  input wire logic remote_output_select,
  input wire logic start,
  input wire logic stop,
  input wire logic key_input_port,
  input wire logic key_pressed,
  input wire logic remote_output_pin,
  input wire logic running,
  input wire rcm_pkg::rcm_requests_t requests
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  property p_sel; !remote_output_select [*2] |-> !remote_output_pin; endproperty
  a_sel: assert property (p_sel) else $error("pin high, select off");
  property p_dis; !timer_array_enable [*2] |-> !running && requests == 4'h0; endproperty
  a_dis: assert property (p_dis) else $error("active while disabled");
  property p_pulse; requests != 4'h0 |=> (requests & $past(requests)) == 4'h0; endproperty
  a_pulse: assert property (p_pulse) else $error("request longer than a cycle");
  property p_go; start && !stop && timer_array_enable && !running |-> ##[1:3] running; endproperty
  a_go: assert property (p_go) else $error("start not taken");
  property p_halt; stop && running && timer_array_enable |-> ##[1:3] !running; endproperty
  a_halt: assert property (p_halt) else $error("stop not taken");
  property p_idle; !running [*3] |-> requests == 4'h0 && !remote_output_pin; endproperty
  a_idle: assert property (p_idle) else $error("activity while idle");
  property p_rst; disable iff (1'b0) srst |=> !running && !remote_output_pin && !key_pressed; endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared");
  property p_key; (!key_input_port && timer_array_enable) [*4] |-> key_pressed; endproperty
  a_key: assert property (p_key) else $error("key press missed");
  c_rise: cover property (requests.mask_rise_request);
  c_pin: cover property ($rose(remote_output_pin));
  c_high: cover property (requests.carrier_high_request && running);
endmodule
bind rcm_remote_carrier_mask_pwm rcm_pwm_chk #(.CNT_W(CNT_W), .PCLK_DIV(PCLK_DIV)) u_chk (.*);
`default_nettype wire

// ==== verification/rcm_emitter.sv ====
// Infrared emitter model: counts flashes, keeps widest
`timescale 1ns/1ps
`default_nettype none
module rcm_emitter (
  input wire logic sys_clk,
  input wire logic led_drive,
  output int flashes,
  output int widest
);
  int run = 0;
  initial flashes = 0;
  initial widest = 0;
  always @(posedge sys_clk) begin
    if (led_drive) begin
      run++;
      if (run == 1) flashes++;
    end else begin
      if (run > widest) widest = run;
      run = 0;
    end
  end
endmodule
`default_nettype wire

// ==== verification/tb_top.sv ====
// Self-checking bench for the remote carrier mask generator
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 0, srst = 1, en = 0, sel = 0, wr = 0, go = 0, halt = 0, key = 1, kp, pin, run;
  rcm_pkg::rcm_counts_t cnt = '0;
  logic [3:0] tout;
  rcm_pkg::rcm_requests_t req;
  int num_errors = 0, checks = 0, f0, flashes, widest;
  always #2.5 clk = ~clk;
  rcm_remote_carrier_mask_pwm #(.PCLK_DIV(2)) u_dut (.sys_clk(clk), .srst(srst), .timer_array_enable(en),
    .remote_output_select(sel), .count_write(wr), .count_data(cnt), .start(go), .stop(halt),
    .key_input_port(key), .key_pressed(kp), .remote_output_pin(pin), .timer_output(tout),
    .running(run), .requests(req));
  rcm_emitter u_led (.sys_clk(clk), .led_drive(pin), .flashes(flashes), .widest(widest));
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s expected %0h seen %0h", name, exp, got);
    end
  endtask
  task automatic pulse(ref logic s);
    s = 1;
    tick(1);
    s = 0;
  endtask
  task automatic load(input logic [15:0] mp, input logic [15:0] ma);
    cnt = {mp, ma, 16'h0009, 16'h0002};
    pulse(wr);
  endtask
  task automatic wait_req(input int b);
    int n = 0;
    tick(1);
    while (req[b] !== 1'b1 && n < 400) begin
      tick(1);
      n++;
    end
    chk("request", 1, req[b]);
  endtask
  task automatic t_key();
    key = 0;
    tick(4);
    chk("key_pressed", 1, kp);
    key = 1;
    tick(4);
    chk("key_pressed", 0, kp);
  endtask
  task automatic t_off();
    sel = 1;
    load(16'h0031, 16'h001d);
    pulse(go);
    tick(3);
    chk("running", 0, run);
    en = 1;
    tick(1);
    pulse(go);
    tick(3);
    chk("running", 1, run);
    f0 = flashes;
    tick(200);
    chk("flashes", f0, flashes);
    pulse(halt);
    tick(3);
  endtask
  task automatic t_burst();
    load(16'h0031, 16'h001d);
    pulse(go);
    wait_req(3);
    f0 = flashes;
    wait_req(2);
    tick(30);
    chk("burst", 1, flashes - f0 >= 2);
    chk("widest", 6, widest[15:0]);
    load(16'h0031, 16'h0000);
    wait_req(3);
    wait_req(3);
    f0 = flashes;
    tick(95);
    chk("flashes", f0, flashes);
    wait_req(0);
    pulse(halt);
    tick(3);
    chk("running", 0, run);
  endtask
  task automatic t_tout();
    logic seen = 0;
    sel = 0;
    load(16'h0031, 16'h001d);
    pulse(go);
    f0 = flashes;
    wait_req(1);
    repeat (150) begin
      tick(1);
      seen |= tout[3];
    end
    chk("timer carrier", 1, seen);
    chk("flashes", f0, flashes);
    pulse(halt);
  endtask
  task automatic close_out();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    tick(20);
    srst = 0;
    t_key();
    t_off();
    t_burst();
    t_tout();
    close_out();
  end
  initial begin
    #100000;
    num_errors++;
    close_out();
  end
endmodule
`default_nettype wire
